// ==== src/tcc_pkg.sv ====
// Constants, address map and carrier types for the timer compare/capture registers
package tcc_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned REG_W       = 16;
  localparam int unsigned NUM_REGS    = 5;

  // Address forms
  localparam logic [7:0]  IO_LOW_MAX  = 8'h3F;
  localparam logic [7:0]  IO_DATA_OFS = 8'h20;
  localparam logic [7:0]  EXT_IO_BASE = 8'h60;

  // I/O offsets of the low range
  localparam logic [7:0]  CAP1_LO_OFS = 8'h26;
  localparam logic [7:0]  CAP1_HI_OFS = 8'h27;

  // Data-space addresses of every low byte; high byte sits one above
  localparam logic [7:0]  CAP1_LO_ADDR  = CAP1_LO_OFS + IO_DATA_OFS;
  localparam logic [7:0]  CMP1C_LO_ADDR = 8'h78;
  localparam logic [7:0]  CMP1C_HI_ADDR = 8'h79;
  localparam logic [7:0]  CMP3C_LO_ADDR = 8'h82;
  localparam logic [7:0]  CMP3C_HI_ADDR = 8'h83;
  localparam logic [7:0]  CMP3B_LO_ADDR = 8'h84;
  localparam logic [7:0]  CMP3B_HI_ADDR = 8'h85;
  localparam logic [7:0]  CMP3A_LO_ADDR = 8'h86;
  localparam logic [7:0]  CMP3A_HI_ADDR = 8'h87;

  // Storage index of each 16-bit register
  localparam int unsigned CAP1_IDX  = 0;
  localparam int unsigned CMP1C_IDX = 1;
  localparam int unsigned CMP3C_IDX = 2;
  localparam int unsigned CMP3B_IDX = 3;
  localparam int unsigned CMP3A_IDX = 4;

  localparam logic [NUM_REGS-1:0][7:0] LO_ADDR = {
    CMP3A_LO_ADDR, CMP3B_LO_ADDR, CMP3C_LO_ADDR, CMP1C_LO_ADDR, CAP1_LO_ADDR
  };

  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [7:0]  TEMP_RESET  = 8'h00;
  localparam logic [7:0]  RDATA_IDLE  = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       io_form;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] cmp1_c;
    logic [15:0] cmp3_a;
    logic [15:0] cmp3_b;
    logic [15:0] cmp3_c;
  } compare_vals_t;

endpackage

// ==== src/timer_compare_capture_regs.sv ====
// Compare and capture registers of two 16-bit timers with shared high-byte latch
// Summary of operation
// - A detected edge on the capture pin loads the capture register with the counter value unless capture_as_top is set.
// - Timer 1 may take its capture trigger from the comparator output instead of the pin.
// - The capture register value is offered as the counter top limit when a mode selects it.
// - Capture reads return both bytes from one instant through an 8-bit high-byte latch.
// - One latch serves all 16-bit registers, so software must not interleave 16-bit accesses.
// - A low-range register reached through data space sits at its offset plus 0x20.
`timescale 1ns/1ps
`default_nettype none

module timer_compare_capture_regs #(
  parameter int unsigned CNT_W = tcc_pkg::REG_W
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire tcc_pkg::bus_req_t      bus_req,
  output logic [tcc_pkg::DATA_W-1:0]  rdata,
  input  wire logic [CNT_W-1:0]       counter_value,
  input  wire logic                   capture_trigger_pin,
  input  wire logic                   comparator_out,
  input  wire logic                   use_comparator,
  input  wire logic                   capture_rising_edge,
  input  wire logic                   capture_as_top,
  output logic [CNT_W-1:0]            capture_top,
  output logic                        capture_event,
  output tcc_pkg::compare_vals_t      compare_vals
);

  if (CNT_W != 2 * tcc_pkg::DATA_W) begin : g_bad_width
    $error("CNT_W must be twice the bus width");
  end

  // Synchronisers: stage 1 feeds stage 2 only; stage 3 is kept for edges
  logic [2:0] pin_sync_q;
  logic [2:0] pin_sync_d;
  logic [2:0] cmp_sync_q;
  logic [2:0] cmp_sync_d;
  logic       pin_edge;
  logic       cmp_edge;
  logic       trig_edge;
  logic       cap_evt_q;
  logic       cap_evt_d;
  logic [2:0] arm_q;
  logic [2:0] arm_d;

  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], capture_trigger_pin};
    cmp_sync_d = {cmp_sync_q[1:0], comparator_out};
    pin_edge   = capture_rising_edge ? (pin_sync_q[1] & ~pin_sync_q[2])
                                     : (~pin_sync_q[1] & pin_sync_q[2]);
    cmp_edge   = capture_rising_edge ? (cmp_sync_q[1] & ~cmp_sync_q[2])
                                     : (~cmp_sync_q[1] & cmp_sync_q[2]);
    // Edges ignored until stage 3 holds a real sample, else a high pin fakes one after reset
    arm_d      = {arm_q[1:0], 1'b1};
    trig_edge  = arm_q[2] & (use_comparator ? cmp_edge : pin_edge);
    // Capture is frozen while the register defines the top, else top would move
    cap_evt_d  = trig_edge & ~capture_as_top;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync_q <= 3'h0;
      cmp_sync_q <= 3'h0;
      cap_evt_q  <= 1'b0;
      arm_q      <= 3'h0;
    end else begin
      pin_sync_q <= pin_sync_d;
      cmp_sync_q <= cmp_sync_d;
      cap_evt_q  <= cap_evt_d;
      arm_q      <= arm_d;
    end
  end

  // Address decode for both access forms
  logic [7:0]                   eff_addr;
  logic                         addr_ok;
  logic                         is_hi;
  logic [tcc_pkg::NUM_REGS-1:0] hit;
  logic                         any_hit;

  always_comb begin
    eff_addr = bus_req.io_form ? 8'(bus_req.addr + tcc_pkg::IO_DATA_OFS) : bus_req.addr;
    // Short form beyond the low range is ignored
    addr_ok  = ~bus_req.io_form || (bus_req.addr <= tcc_pkg::IO_LOW_MAX);
    is_hi    = eff_addr[0];
    for (int i = 0; i < tcc_pkg::NUM_REGS; i++) begin
      hit[i] = addr_ok && (eff_addr[7:1] == tcc_pkg::LO_ADDR[i][7:1]);
    end
    any_hit  = |hit;
  end

  // Register storage
  logic [CNT_W-1:0] regs_q [tcc_pkg::NUM_REGS];
  logic [CNT_W-1:0] regs_d [tcc_pkg::NUM_REGS];
  logic [7:0]       temp_q;
  logic [7:0]       temp_d;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;
  logic [CNT_W-1:0] sel_val;

  for (genvar g = 0; g < tcc_pkg::NUM_REGS; g++) begin : g_reg
    always_comb begin
      regs_d[g] = regs_q[g];
      if (bus_req.wr && hit[g] && !is_hi) begin
        regs_d[g] = {temp_q, bus_req.wdata};
      end
      // A hardware capture beats a same-cycle software write
      if ((g == tcc_pkg::CAP1_IDX) && cap_evt_q) begin
        regs_d[g] = counter_value;
      end
    end

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs_q[g] <= tcc_pkg::REG_RESET;
      end else begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  always_comb begin
    sel_val = '0;
    for (int i = 0; i < tcc_pkg::NUM_REGS; i++) begin
      if (hit[i]) begin
        sel_val = regs_q[i];
      end
    end
    // Single latch for every register
    temp_d = temp_q;
    if (bus_req.wr && any_hit && is_hi) begin
      temp_d = bus_req.wdata;
    end else if (bus_req.rd && any_hit && !is_hi) begin
      temp_d = sel_val[15:8];
    end
    rdata_d = rdata_q;
    if (bus_req.rd) begin
      if (!any_hit) begin
        rdata_d = tcc_pkg::RDATA_IDLE;
      end else if (is_hi) begin
        rdata_d = temp_q;
      end else begin
        rdata_d = sel_val[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_q  <= tcc_pkg::TEMP_RESET;
      rdata_q <= tcc_pkg::RDATA_IDLE;
    end else begin
      temp_q  <= temp_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata               = rdata_q;
  assign capture_top         = regs_q[tcc_pkg::CAP1_IDX];
  assign capture_event       = cap_evt_q;
  // One driver for the whole carrier
  assign compare_vals = '{
    cmp1_c: regs_q[tcc_pkg::CMP1C_IDX],
    cmp3_a: regs_q[tcc_pkg::CMP3A_IDX],
    cmp3_b: regs_q[tcc_pkg::CMP3B_IDX],
    cmp3_c: regs_q[tcc_pkg::CMP3C_IDX]
  };

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_lo_read_cap;
    bus_req.rd && hit[tcc_pkg::CAP1_IDX] && !is_hi && !bus_req.wr;
  endsequence

  sequence s_hi_write(int idx);
    bus_req.wr && hit[idx] && is_hi;
  endsequence

  chk_capture_loads: assert property (
    cap_evt_q |=> capture_top == $past(counter_value))
    else $error("capture did not load counter");

  chk_pin_edge_capture: assert property (
    arm_q[2] && !use_comparator && !capture_as_top && capture_rising_edge
    && pin_sync_q[1] && !pin_sync_q[2] |=> capture_event ##1 capture_top == $past(counter_value))
    else $error("pin edge not captured");

  chk_comparator_source: assert property (
    $rose(cap_evt_q) && $past(use_comparator) |-> $past(cmp_edge))
    else $error("capture from wrong source");

  chk_top_frozen: assert property (
    capture_as_top && $past(capture_as_top) && $past(capture_as_top, 2)
    && !$past(bus_req.wr) |-> $stable(capture_top))
    else $error("top value changed without write");

  chk_atomic_read: assert property (
    s_lo_read_cap ##1 (bus_req.rd && bus_req.addr == tcc_pkg::CAP1_HI_OFS
    && bus_req.io_form && !bus_req.wr) |=> rdata == $past(capture_top[15:8], 2))
    else $error("high byte not from same instant");

  chk_hi_write_buffered: assert property (
    s_hi_write(tcc_pkg::CMP3A_IDX) |=> temp_q == $past(bus_req.wdata)
    && $stable(compare_vals.cmp3_a))
    else $error("high write not held in latch");

  chk_lo_commit: assert property (
    s_hi_write(tcc_pkg::CMP1C_IDX) ##1 (bus_req.wr && hit[tcc_pkg::CMP1C_IDX] && !is_hi)
    |=> compare_vals.cmp1_c == {$past(bus_req.wdata, 2), $past(bus_req.wdata)})
    else $error("16-bit commit wrong");

  chk_short_range: assert property (
    bus_req.io_form && bus_req.addr > tcc_pkg::IO_LOW_MAX |-> !any_hit)
    else $error("short form decoded above range");

  chk_data_alias: assert property (
    !bus_req.io_form && bus_req.addr == tcc_pkg::CAP1_LO_ADDR |-> hit[tcc_pkg::CAP1_IDX])
    else $error("data-space alias not decoded");

  chk_ext_data_only: assert property (
    bus_req.io_form |-> eff_addr < tcc_pkg::EXT_IO_BASE || !addr_ok)
    else $error("extended region reached by short form");

endmodule

`default_nettype wire

// ==== tb/cpu_port_model.sv ====
// Processor-side model driving the byte-wide register bus
`timescale 1ns/1ps
`default_nettype none

module cpu_port_model (
  input  wire logic          clk,
  input  wire logic [7:0]    rdata,
  output tcc_pkg::bus_req_t  bus_req
);
  initial bus_req = '0;

  // Entered at a falling edge; request held over the rising edge that takes it
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    bus_req.wr      = wr;
    bus_req.rd      = ~wr;
    bus_req.io_form = (a <= tcc_pkg::IO_LOW_MAX);
    bus_req.addr    = a;
    bus_req.wdata   = d;
    @(negedge clk);
    q = rdata;
  endtask

  // Deliberate short-form access above the low range; the block must ignore it
  task automatic short_above(input logic wr, input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q);
    bus_req.wr      = wr;
    bus_req.rd      = ~wr;
    bus_req.io_form = 1'b1;
    bus_req.addr    = a;
    bus_req.wdata   = d;
    @(negedge clk);
    q = rdata;
  endtask

  // Released lines show inverted values so stale data cannot pass
  task automatic idle();
    bus_req.rd    = 1'b0;
    bus_req.wr    = 1'b0;
    bus_req.addr  = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
    @(negedge clk);
  endtask
endmodule

`default_nettype wire

// ==== tb/timer_compare_capture_regs_bench.sv ====
// Self-checking bench for the timer compare and capture registers
`timescale 1ns/1ps
`default_nettype none

module timer_compare_capture_regs_bench;
  logic                   clk, resetn, pin, cmp_out, use_cmp, rise, as_top, cap_event;
  logic [15:0]            cnt, cap_top, v;
  logic [7:0]             rdata, b;
  tcc_pkg::bus_req_t      bus_req;
  tcc_pkg::compare_vals_t cmp;
  int                     n_errors, num_checks, cycles;
  logic [7:0]             lo_tbl [5] = '{8'h46, 8'h78, 8'h82, 8'h84, 8'h86};
  logic [15:0]            val_tbl [5] = '{16'hC1D2, 16'hB1C2, 16'h3C3D, 16'h3B3E, 16'h3A3F};

  cpu_port_model cpu (.clk(clk), .rdata(rdata), .bus_req(bus_req));
  timer_compare_capture_regs #(.CNT_W(16)) DUT (
    .clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata), .counter_value(cnt),
    .capture_trigger_pin(pin), .comparator_out(cmp_out), .use_comparator(use_cmp),
    .capture_rising_edge(rise), .capture_as_top(as_top), .capture_top(cap_top),
    .capture_event(cap_event), .compare_vals(cmp));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd16(input logic [7:0] lo, output logic [15:0] q);
    cpu.access(1'b0, lo, 8'h00, q[7:0]);
    cpu.access(1'b0, lo + 8'h01, 8'h00, q[15:8]);
    cpu.idle();
  endtask

  // High byte first, low byte commits
  task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
    cpu.access(1'b1, lo + 8'h01, d[15:8], b);
    cpu.access(1'b1, lo, d[7:0], b);
    cpu.idle();
  endtask

  // Watches a fixed span; the synchroniser needs about three edges
  task automatic capture(input logic exp_evt, input logic [15:0] exp_top);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (cap_event === 1'b1) seen = 1'b1;
    end
    check("capture event", {15'h0000, exp_evt}, {15'h0000, seen});
    check("capture top", exp_top, cap_top);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    {resetn, pin, cmp_out, use_cmp, as_top} = '0;
    rise = 1'b1;
    cnt = 16'h0000;
    {n_errors, num_checks, cycles} = '0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    for (int k = 0; k < 5; k++) begin
      rd16(lo_tbl[k], v);
      check("reset value", 16'h0000, v);
      wr16(lo_tbl[k], val_tbl[k]);
    end
    $display("test reset and write done");
    check("cmp1_c", val_tbl[1], cmp.cmp1_c);
    check("cmp3_c", val_tbl[2], cmp.cmp3_c);
    check("cmp3_b", val_tbl[3], cmp.cmp3_b);
    check("cmp3_a", val_tbl[4], cmp.cmp3_a);
    check("capture as top", val_tbl[0], cap_top);
    for (int k = 0; k < 5; k++) begin
      rd16(lo_tbl[k], v);
      check("readback", val_tbl[k], v);
    end
    rd16(8'h26, v);
    check("short form capture", val_tbl[0], v);
    cpu.access(1'b0, 8'h86, 8'h00, b);
    cpu.access(1'b0, 8'h84, 8'h00, b);
    cpu.access(1'b0, 8'h87, 8'h00, b);
    check("shared latch read", {8'h00, val_tbl[3][15:8]}, {8'h00, b});
    cpu.access(1'b1, 8'h83, 8'h5A, b);
    cpu.access(1'b1, 8'h78, 8'h66, b);
    cpu.idle();
    check("shared latch write", 16'h5A66, cmp.cmp1_c);
    cpu.short_above(1'b1, 8'h66, 8'hEE, b);
    cpu.short_above(1'b0, 8'h66, 8'h00, b);
    cpu.idle();
    check("short form write refused", val_tbl[4], cmp.cmp3_a);
    check("short form read refused", 16'h0000, {8'h00, b});
    $display("test shared latch done");
    cnt = 16'h4321;
    pin = 1'b1;
    capture(1'b1, 16'h4321);
    cpu.access(1'b0, 8'h26, 8'h00, v[7:0]);
    cpu.idle();
    cnt = 16'h9876;
    pin = 1'b0;
    rise = 1'b0;
    capture(1'b1, 16'h9876);
    cpu.access(1'b0, 8'h27, 8'h00, v[15:8]);
    cpu.idle();
    check("atomic capture read", 16'h4321, v);
    rise = 1'b1;
    use_cmp = 1'b1;
    cnt = 16'h0F0F;
    pin = 1'b1;
    capture(1'b0, 16'h9876);
    cmp_out = 1'b1;
    capture(1'b1, 16'h0F0F);
    cnt = 16'h7777;
    cmp_out = 1'b0;
    capture(1'b0, 16'h0F0F);
    as_top = 1'b1;
    cmp_out = 1'b1;
    capture(1'b0, 16'h0F0F);
    $display("test capture done");
    end_of_test();
  end
endmodule

`default_nettype wire
